// file: logic/asp_ctrl.sv
`timescale 1ns/10ps
// Operation
// - While bit 0 enables the converter, every rising trigger edge starts one 12-bit conversion on the next enabled input pin.
// - Each pin has an enable in bit 0 and a 24-bit destination in bits 31:8 of its control.
// - A dropped sample sets bit 24 of general control, and reading that register clears it.
// - The result always sits in the most significant bits of the transmitted word.
// - Width code 0 sends one byte with the upper eight result bits.
// - Width code 1 sends a 16-bit word with four low zero bits, high byte first.
// - Width code 3 sends a 32-bit word with 20 low zero bits, high byte first; code 2 is unused.
// - Bits 15:8 give the number of samples sent before a packet is terminated.
// - With that count at zero the packet stays open until a control register access.
// - Bit 1 switches the converter input to the internal calibration reference.
// - While bit 0 enables the converter, writes to the per-pin controls are ignored.
// - The first six trigger pulses after enabling only calibrate and produce no packets.
module asp_ctrl (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [31:0]           reg_wdata,
  output logic [31:0]                reg_rdata,
  output logic                       reg_rvalid,
  // Trigger pin
  input  wire logic                  trig_pin,
  // Converter core
  output logic                       conv_start,
  output logic [1:0]                 conv_pin,
  output logic                       conv_cal_sel,
  input  wire logic                  conv_done,
  input  wire logic [11:0]           conv_result,
  // Channel-end stream
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output asp_pkg::asp_beat_s         tx_beat
);
  typedef enum logic [1:0] {S_IDLE, S_BYTE, S_END} asp_state_e;

  asp_pkg::asp_pin_s    pin_q [asp_pkg::NUM_PINS];
  asp_pkg::asp_sample_s samp_in;
  asp_pkg::asp_sample_s samp_out;
  asp_pkg::asp_sample_s cur_q;
  asp_state_e           st_q;
  asp_state_e           st_d;
  logic                 en_q;
  logic                 cal_q;
  logic [7:0]           spp_q;
  logic [1:0]           wid_q;
  logic                 drop_q;
  logic [3:0]           pin_en;
  logic [2:0]           trig_sync_q;
  logic                 trig_lvl_q;
  logic                 trig_rise;
  logic [2:0]           cal_cnt_q;
  logic                 skip_q;
  logic [1:0]           last_pin_q;
  logic                 fifo_ready;
  logic                 fifo_out_valid;
  logic                 push;
  logic                 drop_set;
  logic                 rd_gen;
  logic                 reg_hit;
  logic                 close_pend_q;
  logic                 open_q;
  logic [1:0]           idx_q;
  logic [7:0]           samp_cnt_q;
  logic                 adv;
  logic                 pop;
  logic                 emit;
  logic                 last_byte;

  function automatic logic [1:0] next_pin(input logic [1:0] last, input logic [3:0] en);
    logic [1:0] cand;
    logic [1:0] pick;
    pick = last;
    for (int i = 4; i >= 1; i--) begin
      cand = last + 2'(i);
      if (en[cand]) pick = cand;
    end
    return pick;
  endfunction
  function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] idx);
    return word[31 - 8*idx -: 8];
  endfunction

  assign pin_en = {pin_q[3].en, pin_q[2].en, pin_q[1].en, pin_q[0].en};

  // Register port.
  assign reg_hit = (reg_addr <= asp_pkg::ADDR_PIN3 && reg_addr[1:0] == 2'h0) ||
                   reg_addr == asp_pkg::ADDR_GEN;
  assign rd_gen  = reg_rd && reg_addr == asp_pkg::ADDR_GEN;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < asp_pkg::NUM_PINS; p++) pin_q[p] <= '0;
    end else if (reg_wr && !en_q && reg_addr <= asp_pkg::ADDR_PIN3 &&
                 reg_addr[1:0] == 2'h0) begin
      pin_q[reg_addr[3:2]].dest <= reg_wdata[asp_pkg::PIN_DEST_LSB +: asp_pkg::DEST_W];
      pin_q[reg_addr[3:2]].en   <= reg_wdata[asp_pkg::PIN_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q  <= 1'b0;
      cal_q <= 1'b0;
      spp_q <= asp_pkg::SPP_RST;
      wid_q <= asp_pkg::WID_RST;
    end else if (reg_wr && reg_addr == asp_pkg::ADDR_GEN) begin
      en_q  <= reg_wdata[asp_pkg::GEN_EN_BIT];
      cal_q <= reg_wdata[asp_pkg::GEN_CAL_BIT];
      spp_q <= reg_wdata[asp_pkg::GEN_SPP_LSB +: asp_pkg::SPP_W];
      // The reserved width code would send a malformed sample, so it is refused.
      if (reg_wdata[asp_pkg::GEN_WID_LSB +: 2] != asp_pkg::WID_RSVD) begin
        wid_q <= reg_wdata[asp_pkg::GEN_WID_LSB +: 2];
      end
    end
  end

  // A drop in the same cycle as the clearing read survives the read.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) drop_q <= asp_pkg::DROP_RST;
    else if (drop_set) drop_q <= 1'b1;
    else if (rd_gen) drop_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= '0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= '0;
      if (reg_rd && reg_addr == asp_pkg::ADDR_GEN) begin
        reg_rdata <= {7'h00, drop_q, 6'h00, wid_q, spp_q, 6'h00, cal_q, en_q};
      end else if (reg_rd && reg_hit) begin
        reg_rdata <= {pin_q[reg_addr[3:2]].dest, 7'h00, pin_q[reg_addr[3:2]].en};
      end
    end
  end

  // Trigger pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_q <= 3'h0;
      trig_lvl_q  <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trig_pin};
      if (trig_sync_q[1] == trig_sync_q[2]) trig_lvl_q <= trig_sync_q[2];
    end
  end
  assign trig_rise = trig_sync_q[1] && trig_sync_q[2] && !trig_lvl_q;

  // Conversion scheduling.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cal_cnt_q <= 3'h0;
    else if (!en_q) cal_cnt_q <= 3'h0;
    else if (trig_rise && cal_cnt_q < asp_pkg::CAL_PULSES) cal_cnt_q <= cal_cnt_q + 3'h1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      conv_pin   <= 2'h0;
      last_pin_q <= 2'h3;
      skip_q     <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (trig_rise && en_q && pin_en != 4'h0) begin
        conv_start <= 1'b1;
        conv_pin   <= next_pin(last_pin_q, pin_en);
        last_pin_q <= next_pin(last_pin_q, pin_en);
        skip_q     <= cal_cnt_q < asp_pkg::CAL_PULSES;
      end
    end
  end

  assign conv_cal_sel = cal_q;
  // Left alignment for every width: the serialiser just sends the top bytes.
  assign samp_in.dest = pin_q[conv_pin].dest;
  assign samp_in.word = {conv_result, 20'h00000};
  assign samp_in.wid  = wid_q;
  assign push         = conv_done && !skip_q && en_q;
  assign drop_set     = push && !fifo_ready;

  asp_fifo #(
    .WIDTH ($bits(asp_pkg::asp_sample_s)),
    .DEPTH (asp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (samp_in),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (samp_out)
  );

  // Packet serialiser.
  assign adv       = !tx_valid || tx_ready;
  assign last_byte = idx_q == cur_q.wid;
  assign pop       = st_q == S_IDLE && adv && fifo_out_valid &&
                     !(close_pend_q && open_q);
  assign emit      = adv && (st_q == S_BYTE || st_q == S_END);

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (adv && close_pend_q && open_q) st_d = S_END;
        else if (pop) st_d = S_BYTE;
      end
      S_BYTE: begin
        if (adv && last_byte) begin
          if (spp_q != 8'h00 && samp_cnt_q + 8'h01 == spp_q) st_d = S_END;
          else st_d = S_IDLE;
        end
      end
      S_END: begin
        if (adv) st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) st_q <= S_IDLE;
    else st_q <= st_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q      <= '0;
      idx_q      <= 2'h0;
      samp_cnt_q <= 8'h00;
      open_q     <= 1'b0;
    end else begin
      if (pop) begin
        cur_q <= samp_out;
        idx_q <= 2'h0;
      end
      if (st_q == S_BYTE && adv) begin
        idx_q  <= idx_q + 2'h1;
        open_q <= 1'b1;
        if (last_byte) samp_cnt_q <= samp_cnt_q + 8'h01;
      end
      if (st_q == S_END && adv) begin
        samp_cnt_q <= 8'h00;
        open_q     <= 1'b0;
      end
    end
  end

  // A control access while the packet count is zero asks for the packet to close.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) close_pend_q <= 1'b0;
    else if ((reg_wr || reg_rd) && reg_hit && spp_q == 8'h00) close_pend_q <= 1'b1;
    else if (st_q == S_END && adv) close_pend_q <= 1'b0;
    else if (!open_q && st_q == S_IDLE) close_pend_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_beat  <= '0;
    end else if (adv) begin
      tx_valid     <= emit;
      tx_beat.dest <= cur_q.dest;
      tx_beat.eop  <= st_q == S_END;
      tx_beat.data <= (st_q == S_BYTE) ? byte_of(cur_q.word, idx_q) : 8'h00;
    end
  end

  property p_drop_set;
    @(posedge ref_clk) disable iff (!rst_n) drop_set |=> drop_q;
  endproperty
  a_drop_set: assert property (p_drop_set) else $error("drop not flagged");
  property p_drop_clr;
    @(posedge ref_clk) disable iff (!rst_n) rd_gen && !drop_set |=> !drop_q;
  endproperty
  a_drop_clr: assert property (p_drop_clr) else $error("drop flag kept after read");
  property p_pin_lock;
    @(posedge ref_clk) disable iff (!rst_n)
      reg_wr && en_q && reg_addr == asp_pkg::ADDR_PIN0 |=> $stable(pin_q[0]);
  endproperty
  a_pin_lock: assert property (p_pin_lock) else $error("pin control changed while enabled");
  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
      trig_rise && en_q && pin_en != 4'h0 |=> conv_start && pin_en[conv_pin];
  endproperty
  a_start: assert property (p_start) else $error("conversion not started on enabled pin");
  property p_no_pin;
    @(posedge ref_clk) disable iff (!rst_n) pin_en == 4'h0 |=> !conv_start;
  endproperty
  a_no_pin: assert property (p_no_pin) else $error("conversion with no pin enabled");
  property p_msb_first;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q == S_BYTE && idx_q == 2'h0 && adv |=> tx_valid && tx_beat.data == cur_q.word[31:24];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first byte not high byte");
  property p_byte_mode;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q == S_BYTE && cur_q.wid == asp_pkg::WID_8 && adv |=> st_q != S_BYTE;
  endproperty
  a_byte_mode: assert property (p_byte_mode) else $error("8-bit sample sent more bytes");
  property p_pad16;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q == S_BYTE && cur_q.wid == asp_pkg::WID_16 && idx_q == 2'h1 && adv
      |=> tx_beat.data[3:0] == 4'h0 ##0 st_q != S_BYTE;
  endproperty
  a_pad16: assert property (p_pad16) else $error("16-bit sample padding wrong");
  property p_pad32;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q == S_BYTE && cur_q.wid == asp_pkg::WID_32 && idx_q == 2'h3 && adv
      |=> tx_beat.data == 8'h00;
  endproperty
  a_pad32: assert property (p_pad32) else $error("32-bit sample padding wrong");
  property p_spp;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q == S_BYTE && adv && last_byte && spp_q != 8'h00 && samp_cnt_q + 8'h01 == spp_q
      |=> st_q == S_END;
  endproperty
  a_spp: assert property (p_spp) else $error("packet not closed at count");
  property p_open_close;
    @(posedge ref_clk) disable iff (!rst_n)
      st_q == S_IDLE && adv && close_pend_q && open_q |=> st_q == S_END ##1 !tx_valid || tx_beat.eop;
  endproperty
  a_open_close: assert property (p_open_close) else $error("open packet not closed");
  property p_cal_quiet;
    @(posedge ref_clk) disable iff (!rst_n) conv_done && skip_q |-> !push;
  endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("calibration pulse queued a sample");

endmodule

// file: logic/asp_pkg.sv
package asp_pkg;

  // Register map, byte addresses on the peripheral access path.
  localparam logic [7:0] ADDR_PIN0     = 8'h00;
  localparam logic [7:0] ADDR_PIN3     = 8'h0c;
  localparam logic [7:0] ADDR_GEN      = 8'h20;
  localparam int unsigned NUM_PINS     = 4;

  // Per-pin control fields.
  localparam int unsigned PIN_EN_BIT   = 0;
  localparam int unsigned PIN_DEST_LSB = 8;
  localparam int unsigned DEST_W       = 24;

  // General control fields.
  localparam int unsigned GEN_EN_BIT   = 0;
  localparam int unsigned GEN_CAL_BIT  = 1;
  localparam int unsigned GEN_SPP_LSB  = 8;
  localparam int unsigned SPP_W        = 8;
  localparam int unsigned GEN_WID_LSB  = 16;
  localparam int unsigned GEN_DROP_BIT = 24;

  // Reset values of the general control fields.
  localparam logic [1:0] WID_RST       = 2'h1;
  localparam logic [7:0] SPP_RST       = 8'h01;
  localparam logic       DROP_RST      = 1'b1;

  // Sample width codes; the code equals the index of the last byte sent.
  localparam logic [1:0] WID_8         = 2'h0;
  localparam logic [1:0] WID_16        = 2'h1;
  localparam logic [1:0] WID_RSVD      = 2'h2;
  localparam logic [1:0] WID_32        = 2'h3;

  localparam int unsigned RESULT_W     = 12;
  localparam int unsigned WORD_W       = 32;
  localparam logic [2:0] CAL_PULSES    = 3'h6;
  localparam int unsigned FIFO_DEPTH   = 8;

  typedef struct packed {
    logic [DEST_W-1:0] dest;
    logic              en;
  } asp_pin_s;

  typedef struct packed {
    logic [DEST_W-1:0] dest;
    logic [WORD_W-1:0] word;
    logic [1:0]        wid;
  } asp_sample_s;

  typedef struct packed {
    logic [7:0]        data;
    logic [DEST_W-1:0] dest;
    logic              eop;
  } asp_beat_s;

endpackage

// file: logic/asp_fifo.sv
`timescale 1ns/10ps
// Read data come out of a register stage, so the queue holds DEPTH words in
// memory plus one in the output register; DEPTH must be a power of two.
module asp_fifo #(
  parameter int unsigned WIDTH = 58,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_q != '0) && (!out_valid || out_ready);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + AW'(1);
      if (pop) rd_ptr_q <= rd_ptr_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

// file: verif/asp_sink_model.sv
`timescale 1ns/10ps
// Channel-end stand-in. It can stall outright or accept only every other
// cycle, so the stream has to hold a beat across both kinds of wait.
module asp_sink_model (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Stream
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  input  wire asp_pkg::asp_beat_s tx_beat,
  // Pacing
  input  wire logic               stall,
  input  wire logic               slow
);
  asp_pkg::asp_beat_s q[$];
  logic               odd_q = 1'b0;

  initial tx_ready = 1'b0;

  always @(posedge ref_clk) begin
    if (rst_n && tx_valid && tx_ready) begin
      q.push_back(tx_beat);
    end
    #1;
    odd_q = ~odd_q;
    tx_ready = rst_n && !stall && (!slow || odd_q);
  end
endmodule

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_wdata = 32'h0;
  logic [31:0]        reg_rdata;
  logic               reg_rvalid;
  logic               trig_pin = 1'b0;
  logic               conv_start;
  logic [1:0]         conv_pin;
  logic               conv_cal_sel;
  logic               conv_done = 1'b0;
  logic [11:0]        conv_result = 12'h0;
  logic               tx_valid;
  logic               tx_ready;
  asp_pkg::asp_beat_s tx_beat;
  logic               stall = 1'b0;
  logic               slow = 1'b0;
  logic [2:0]         busy_cnt = 3'h0;
  logic [1:0]         exp_pin = 2'h0;
  logic [1:0]         last_pin = 2'h0;
  int                 starts = 0;
  int                 error_cnt = 0;
  int                 compares = 0;

  asp_ctrl i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .trig_pin(trig_pin), .conv_start(conv_start),
    .conv_pin(conv_pin), .conv_cal_sel(conv_cal_sel), .conv_done(conv_done),
    .conv_result(conv_result), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_beat(tx_beat)
  );

  asp_sink_model i_sink (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_beat(tx_beat), .stall(stall), .slow(slow)
  );

  always #20 ref_clk = ~ref_clk;

  // Converter stand-in: the result names the pin, so a wrong pin shows up.
  always @(posedge ref_clk) begin
    #1;
    conv_done = (busy_cnt == 3'h1);
    conv_result = conv_cal_sel ? 12'h3e8 : {10'h2ab, conv_pin};
    if (conv_start) begin
      busy_cnt = 3'h4;
      starts++;
    end else if (busy_cnt != 3'h0) begin
      busy_cnt = busy_cnt - 3'h1;
    end
  end

  function automatic logic [31:0] gen(input logic [1:0] wid, input logic [7:0] spp,
                                      input logic cal, input logic en);
    return {14'h0, wid, spp, 6'h0, cal, en};
  endfunction

  function automatic logic [23:0] dest_of(input logic [1:0] pin);
    return (pin == 2'h0) ? 24'habcdef : 24'h123456;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    @(posedge ref_clk);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    chk("read valid", 32'h1, {31'h0, reg_rvalid});
    chk("read data", exp, reg_rdata);
  endtask

  task automatic trig();
    @(posedge ref_clk);
    #1;
    trig_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    trig_pin = 1'b0;
    last_pin = exp_pin;
    exp_pin = exp_pin ^ 2'h1;
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic pop(output asp_pkg::asp_beat_s b);
    int n;
    n = 0;
    while (i_sink.q.size() == 0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    b = '0;
    if (i_sink.q.size() == 0) begin
      chk("beat arrival", 32'h1, 32'h0);
    end else begin
      b = i_sink.q.pop_front();
    end
  endtask

  task automatic end_chk();
    asp_pkg::asp_beat_s b;
    pop(b);
    chk("packet end", 32'h1, {31'h0, b.eop});
  endtask

  task automatic sample(input logic [1:0] wid, input logic [11:0] res, input logic last);
    logic [31:0]        word;
    asp_pkg::asp_beat_s b;
    word = {res, 20'h0};
    for (int i = 0; i <= int'(wid); i++) begin
      pop(b);
      chk("beat data", {24'h0, word[31-8*i -: 8]}, {24'h0, b.data});
      chk("beat dest", {8'h0, dest_of(last_pin)}, {8'h0, b.dest});
      chk("beat end", 32'h0, {31'h0, b.eop});
    end
    if (last) end_chk();
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [1:0] wids[3];
    wids = '{asp_pkg::WID_16, asp_pkg::WID_8, asp_pkg::WID_32};
    repeat (10) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    rd(asp_pkg::ADDR_GEN, 32'h0101_0100);
    rd(asp_pkg::ADDR_GEN, 32'h0001_0100);
    rd(8'h10, 32'h0);
    wr(asp_pkg::ADDR_PIN0, 32'habcdef01);
    wr(8'h04, 32'h12345601);
    rd(8'h04, 32'h12345601);
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_16, 8'h01, 1'b0, 1'b1));
    wr(asp_pkg::ADDR_PIN0, 32'h0);
    rd(asp_pkg::ADDR_PIN0, 32'habcdef01);
    repeat (6) trig();
    chk("calibration beats", 32'h0, 32'(i_sink.q.size()));
    for (int k = 0; k < 3; k++) begin
      wr(asp_pkg::ADDR_GEN, gen(wids[k], 8'h01, 1'b0, 1'b1));
      trig();
      sample(wids[k], {10'h2ab, last_pin}, 1'b1);
    end
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_RSVD, 8'h02, 1'b0, 1'b1));
    rd(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_32, 8'h02, 1'b0, 1'b1));
    trig();
    sample(asp_pkg::WID_32, {10'h2ab, last_pin}, 1'b0);
    trig();
    sample(asp_pkg::WID_32, {10'h2ab, last_pin}, 1'b1);
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_8, 8'h00, 1'b0, 1'b1));
    trig();
    sample(asp_pkg::WID_8, {10'h2ab, last_pin}, 1'b0);
    trig();
    sample(asp_pkg::WID_8, {10'h2ab, last_pin}, 1'b0);
    chk("open packet", 32'h0, 32'(i_sink.q.size()));
    rd(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_8, 8'h00, 1'b0, 1'b1));
    end_chk();
    // Only ten samples fit between queue and output stage, so some are lost.
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_32, 8'h01, 1'b0, 1'b1));
    stall = 1'b1;
    repeat (14) trig();
    rd(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_32, 8'h01, 1'b0, 1'b1) | 32'h0100_0000);
    stall = 1'b0;
    slow = 1'b1;
    repeat (200) @(posedge ref_clk);
    chk("drained beats", 32'h32, 32'(i_sink.q.size()));
    i_sink.q.delete();
    rd(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_32, 8'h01, 1'b0, 1'b1));
    slow = 1'b0;
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_16, 8'h01, 1'b1, 1'b1));
    chk("reference select", 32'h1, {31'h0, conv_cal_sel});
    trig();
    repeat (20) @(posedge ref_clk);
    i_sink.q.delete();
    trig();
    sample(asp_pkg::WID_16, 12'h3e8, 1'b1);
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_16, 8'h01, 1'b0, 1'b0));
    chk("reference select", 32'h0, {31'h0, conv_cal_sel});
    wr(asp_pkg::ADDR_PIN0, 32'h0);
    wr(8'h04, 32'h0);
    wr(asp_pkg::ADDR_GEN, gen(asp_pkg::WID_16, 8'h01, 1'b0, 1'b1));
    begin
      int s0;
      s0 = starts;
      trig();
      chk("start without pins", 32'(s0), 32'(starts));
    end
    wrap_up();
  end
endmodule
